/* rtl/gas_amp_battest_ctrl_regs.v */
// configuration registers for the gas sensor front end and battery test load
//
// Overview of operation
// - bit 7 set inserts 100 kOhm between amplifier output and output pin
// - bit 6 set closes the feedback path through the selected resistance
// - bit 5 set inserts 1 kOhm from inverting input to negative pin
// - bit 4 set feeds positive input from millivolt reference, else positive pin
// - load current codes 0..5 give 10..20 mA; codes 6, 7 reserved
// - amplifier register bit 7 enables the 300 mV reference buffer
// - bits 6-5 choose 1.25, 2.5, 3.75 or 5 mV reference
// - bits 4-3 choose 1100, 300, 500 or 800 kOhm feedback
// - bit 2 makes test drive pull down when 0, up when 1
// - bit 1 routes the test drive onto the reference pin
// - bit 0 turns the gas amplifier on
// - amplifier register at offset 0xd resets to zero
// - boost settings register at offset 0xe resets to 0xf2
// - switch and battery test register at offset 0xc resets to zero
`timescale 1ns/10ps
`include "gas_amp_battest_defs.vh"
module gas_amp_battest_ctrl_regs (
  input  wire       clock,
  input  wire       rst,
  input  wire       regWrite,
  input  wire       regRead,
  input  wire [3:0] regAddr,
  input  wire [7:0] regWriteData,
  output wire [7:0] regReadData,
  output wire       regReadValid,
  output reg        gasOutResistorSw_q,
  output reg        gasGainResistorSw_q,
  output reg        gasInResistorSw_q,
  output reg        gasReferenceSw_q,
  output reg  [2:0] batteryLoadCurrent_q,
  output reg        batteryLoadCodeReserved_q,
  output reg        ref300mvBufferOn_q,
  output reg  [1:0] gasReferenceLevel_q,
  output reg  [1:0] gasFeedbackSelect_q,
  output reg        gasTestDriveDir_q,
  output reg        gasTestDriveOn_q,
  output reg        gasAmplifierOn_q,
  output reg  [7:0] boostSettings_q
);
  // bank bytes as held by the three registers
  wire [7:0] switchReg;
  wire [7:0] ampReg;
  wire [7:0] boostReg;

  // reset images of the bytes; each control output except the reserved-code flag resets to its own field of them
  localparam [7:0] SWITCH_RESET = `RST_GAS_SWITCH_BATTERY_TEST;
  localparam [7:0] AMP_RESET    = `RST_GAS_AMP_CONFIG;
  localparam [7:0] BOOST_RESET  = `RST_BOOST_SETTINGS;

  // next values of the control outputs, one for each output flip-flop below
  wire       gasOutResistorSw_d;
  wire       gasGainResistorSw_d;
  wire       gasInResistorSw_d;
  wire       gasReferenceSw_d;
  wire [2:0] batteryLoadCurrent_d;
  wire       batteryLoadCodeReserved_d;
  wire       ref300mvBufferOn_d;
  wire [1:0] gasReferenceLevel_d;
  wire [1:0] gasFeedbackSelect_d;
  wire       gasTestDriveDir_d;
  wire       gasTestDriveOn_d;
  wire       gasAmplifierOn_d;
  wire [7:0] boostSettings_d;

  // true for a strobe aimed at one offset; the three write decodes share this
  // compare so a change of decode width stays in one place
  function addr_hits;
    input       strobe;
    input [3:0] addr;
    input [3:0] offset;
    begin
      addr_hits = strobe && (addr == offset);
    end
  endfunction

  // load current codes above the last legal one have no defined current;
  // the compare lives here so every user of the flag agrees on the limit
  function code_is_reserved;
    input [2:0] code;
    begin
      code_is_reserved = (code > `LOAD_CURRENT_LAST_LEGAL);
    end
  endfunction

  // bus timing: a write lands in its byte at the strobe edge and reaches the
  // control outputs one edge later; a read answers at its own strobe edge
  // with the byte as it stood before any write in that same cycle; strobes
  // may come back to back, nothing here waits or stalls
  // decoded write strobes; the bus shares this clock, so no synchroniser
  wire switchWrite = addr_hits(regWrite, regAddr, `OFS_GAS_SWITCH_BATTERY_TEST);
  wire ampWrite    = addr_hits(regWrite, regAddr, `OFS_GAS_AMP_CONFIG);
  wire boostWrite  = addr_hits(regWrite, regAddr, `OFS_BOOST_SETTINGS);

  // reserved bit 3 is masked so it stays zero whatever is written
  reg_byte #(
    .RESET_VALUE (`RST_GAS_SWITCH_BATTERY_TEST),
    .WRITE_MASK  (`WRITE_MASK_SWITCH_BATTERY)
  ) u_switch (
    .clock     (clock),
    .rst       (rst),
    .writeEn   (switchWrite),
    .writeData (regWriteData),
    .value_q   (switchReg)
  );

  reg_byte #(
    .RESET_VALUE (`RST_GAS_AMP_CONFIG),
    .WRITE_MASK  (8'hff)
  ) u_amp (
    .clock     (clock),
    .rst       (rst),
    .writeEn   (ampWrite),
    .writeData (regWriteData),
    .value_q   (ampReg)
  );

  // boost fields are only held here; their meaning lives in the boost block
  reg_byte #(
    .RESET_VALUE (`RST_BOOST_SETTINGS),
    .WRITE_MASK  (8'hff)
  ) u_boost (
    .clock     (clock),
    .rst       (rst),
    .writeEn   (boostWrite),
    .writeData (regWriteData),
    .value_q   (boostReg)
  );

  read_mux u_read (
    .clock       (clock),
    .rst         (rst),
    .readEn      (regRead),
    .readAddr    (regAddr),
    .switchReg   (switchReg),
    .ampReg      (ampReg),
    .boostReg    (boostReg),
    .readData_q  (regReadData),
    .readValid_q (regReadValid)
  );

  // analog controls are re-registered so they follow the bank one edge later;
  // the extra edge costs a cycle of latency but keeps every output straight
  // off a flip-flop, so no decode glitch ever reaches an analog switch
  // switch byte fields
  assign gasOutResistorSw_d = switchReg[`POS_OUT_RESISTOR_SW];
  assign gasGainResistorSw_d = switchReg[`POS_GAIN_RESISTOR_SW];
  assign gasInResistorSw_d = switchReg[`POS_IN_RESISTOR_SW];
  assign gasReferenceSw_d = switchReg[`POS_REFERENCE_SW];
  assign batteryLoadCurrent_d =
    switchReg[`POS_LOAD_CURRENT_HI:`POS_LOAD_CURRENT_LO];

  // reserved codes are kept as written and only flagged; software must avoid them
  assign batteryLoadCodeReserved_d =
    code_is_reserved(switchReg[`POS_LOAD_CURRENT_HI:`POS_LOAD_CURRENT_LO]);

  // amplifier byte fields
  assign ref300mvBufferOn_d = ampReg[`POS_REF_BUFFER_ON];
  assign gasReferenceLevel_d = ampReg[`POS_REF_LEVEL_HI:`POS_REF_LEVEL_LO];
  assign gasFeedbackSelect_d = ampReg[`POS_FEEDBACK_HI:`POS_FEEDBACK_LO];
  assign gasTestDriveDir_d = ampReg[`POS_TEST_DRIVE_DIR];
  assign gasTestDriveOn_d = ampReg[`POS_TEST_DRIVE_ON];
  assign gasAmplifierOn_d = ampReg[`POS_AMPLIFIER_ON];

  // boost byte passes whole; its fields belong to the boost converter
  assign boostSettings_d = boostReg;

  // output resistor switch; 1 puts 100 kOhm in series with the output pin
  // a glitch here would kick the sensor output, hence the clean flip-flop
  always @(posedge clock) begin
    if (rst) begin
      gasOutResistorSw_q <= SWITCH_RESET[`POS_OUT_RESISTOR_SW];
    end else begin
      gasOutResistorSw_q <= gasOutResistorSw_d;
    end
  end

  // feedback switch; 0 leaves the feedback path open
  // software should pick the feedback value before closing this switch,
  // since the two fields sit in different bytes and cannot change together
  always @(posedge clock) begin
    if (rst) begin
      gasGainResistorSw_q <= SWITCH_RESET[`POS_GAIN_RESISTOR_SW];
    end else begin
      gasGainResistorSw_q <= gasGainResistorSw_d;
    end
  end

  // input resistor switch on the path to the negative sensor pin
  // 1 inserts 1 kOhm, 0 gives a direct path
  always @(posedge clock) begin
    if (rst) begin
      gasInResistorSw_q <= SWITCH_RESET[`POS_IN_RESISTOR_SW];
    end else begin
      gasInResistorSw_q <= gasInResistorSw_d;
    end
  end

  // positive input source; 0 takes the positive sensor pin, 1 the mV reference
  // the reference level itself is chosen in the amplifier byte
  always @(posedge clock) begin
    if (rst) begin
      gasReferenceSw_q <= SWITCH_RESET[`POS_REFERENCE_SW];
    end else begin
      gasReferenceSw_q <= gasReferenceSw_d;
    end
  end

  // battery test current code, 10 mA plus 2 mA per step up to code 5
  // the load itself is switched elsewhere; this only holds the code,
  // so a reserved code reaches the load stage together with its flag
  always @(posedge clock) begin
    if (rst) begin
      batteryLoadCurrent_q <= SWITCH_RESET[`POS_LOAD_CURRENT_HI:`POS_LOAD_CURRENT_LO];
    end else begin
      batteryLoadCurrent_q <= batteryLoadCurrent_d;
    end
  end

  // flag for codes 6 and 7 so the load stage can refuse them
  // the code is kept as written, so a read shows what software sent
  always @(posedge clock) begin
    if (rst) begin
      batteryLoadCodeReserved_q <= 1'b0;
    end else begin
      batteryLoadCodeReserved_q <= batteryLoadCodeReserved_d;
    end
  end

  // amplifier byte controls, then the boost copy
  // 300 mV reference buffer enable
  // left off by reset so the buffer draws no current until asked
  always @(posedge clock) begin
    if (rst) begin
      ref300mvBufferOn_q <= AMP_RESET[`POS_REF_BUFFER_ON];
    end else begin
      ref300mvBufferOn_q <= ref300mvBufferOn_d;
    end
  end

  // millivolt reference level code, 1.25 mV per step
  // changes reach the analog side one edge after the bank
  always @(posedge clock) begin
    if (rst) begin
      gasReferenceLevel_q <= AMP_RESET[`POS_REF_LEVEL_HI:`POS_REF_LEVEL_LO];
    end else begin
      gasReferenceLevel_q <= gasReferenceLevel_d;
    end
  end

  // feedback resistance code; code 0 is the largest value, not the smallest
  // only takes effect while the feedback switch is closed
  always @(posedge clock) begin
    if (rst) begin
      gasFeedbackSelect_q <= AMP_RESET[`POS_FEEDBACK_HI:`POS_FEEDBACK_LO];
    end else begin
      gasFeedbackSelect_q <= gasFeedbackSelect_d;
    end
  end

  // test drive direction; 0 pulls down, 1 pulls up
  // set the direction before enabling the drive to avoid a wrong-way pulse;
  // both sit in one byte, so a single write can change them together
  always @(posedge clock) begin
    if (rst) begin
      gasTestDriveDir_q <= AMP_RESET[`POS_TEST_DRIVE_DIR];
    end else begin
      gasTestDriveDir_q <= gasTestDriveDir_d;
    end
  end

  // test drive enable onto the reference pin
  // the drive shares the reference pin, so keep it off in normal sensing
  always @(posedge clock) begin
    if (rst) begin
      gasTestDriveOn_q <= AMP_RESET[`POS_TEST_DRIVE_ON];
    end else begin
      gasTestDriveOn_q <= gasTestDriveOn_d;
    end
  end

  // gas amplifier enable
  // the switch settings above only matter while the amplifier is on
  always @(posedge clock) begin
    if (rst) begin
      gasAmplifierOn_q <= AMP_RESET[`POS_AMPLIFIER_ON];
    end else begin
      gasAmplifierOn_q <= gasAmplifierOn_d;
    end
  end

  // boost settings copy; resets to its own non-zero image
  // the boost block decodes the fields, this block only holds them
  always @(posedge clock) begin
    if (rst) begin
      boostSettings_q <= BOOST_RESET;
    end else begin
      boostSettings_q <= boostSettings_d;
    end
  end
endmodule // gas_amp_battest_ctrl_regs

/* rtl/gas_amp_battest_defs.vh */
// register offsets, field positions and reset values of the gas amplifier and battery test bank
`ifndef GAS_AMP_BATTEST_DEFS_VH
`define GAS_AMP_BATTEST_DEFS_VH

`define OFS_GAS_SWITCH_BATTERY_TEST 4'hc
`define OFS_GAS_AMP_CONFIG          4'hd
`define OFS_BOOST_SETTINGS          4'he

`define RST_GAS_SWITCH_BATTERY_TEST 8'h00
`define RST_GAS_AMP_CONFIG          8'h00
`define RST_BOOST_SETTINGS          8'hf2

// sensor / battery test register fields
`define POS_OUT_RESISTOR_SW         7
`define POS_GAIN_RESISTOR_SW        6
`define POS_IN_RESISTOR_SW          5
`define POS_REFERENCE_SW            4
`define POS_SWITCH_RESERVED         3
`define POS_LOAD_CURRENT_HI         2
`define POS_LOAD_CURRENT_LO         0
`define WRITE_MASK_SWITCH_BATTERY   8'hf7
`define LOAD_CURRENT_LAST_LEGAL     3'h5

// gas amplifier register fields
`define POS_REF_BUFFER_ON           7
`define POS_REF_LEVEL_HI            6
`define POS_REF_LEVEL_LO            5
`define POS_FEEDBACK_HI             4
`define POS_FEEDBACK_LO             3
`define POS_TEST_DRIVE_DIR          2
`define POS_TEST_DRIVE_ON           1
`define POS_AMPLIFIER_ON            0

`endif

/* rtl/reg_byte.v */
// one 8-bit register with synchronous reset value and per-bit write mask
`timescale 1ns/10ps
module reg_byte #(
  parameter [7:0] RESET_VALUE = 8'h00,
  parameter [7:0] WRITE_MASK  = 8'hff
) (
  input  wire       clock,
  input  wire       rst,
  input  wire       writeEn,
  input  wire [7:0] writeData,
  output reg  [7:0] value_q
);
  // masked bits keep their reset value forever
  always @(posedge clock) begin
    if (rst) begin
      value_q <= RESET_VALUE;
    end else if (writeEn) begin
      value_q <= (writeData & WRITE_MASK) | (RESET_VALUE & ~WRITE_MASK);
    end
  end
endmodule // reg_byte

/* rtl/read_mux.v */
// registered read data selection for the bank
`timescale 1ns/10ps
`include "gas_amp_battest_defs.vh"
module read_mux (
  input  wire       clock,
  input  wire       rst,
  input  wire       readEn,
  input  wire [3:0] readAddr,
  input  wire [7:0] switchReg,
  input  wire [7:0] ampReg,
  input  wire [7:0] boostReg,
  output reg  [7:0] readData_q,
  output reg        readValid_q
);
  // unmapped offsets answer zero so the bus never sees stale data
  always @(posedge clock) begin
    if (rst) begin
      readData_q  <= 8'h00;
      readValid_q <= 1'b0;
    end else begin
      readValid_q <= readEn;
      if (readEn) begin
        case (readAddr)
          `OFS_GAS_SWITCH_BATTERY_TEST: readData_q <= switchReg;
          `OFS_GAS_AMP_CONFIG:          readData_q <= ampReg;
          `OFS_BOOST_SETTINGS:          readData_q <= boostReg;
          default:                      readData_q <= 8'h00;
        endcase
      end
    end
  end
endmodule // read_mux

/* tb/gas_amp_battest_ctrl_regs_asserts.sv */
// concurrent checks on the gas amplifier register bank ports
`timescale 1ns/10ps
module gas_amp_checks (
  input wire       clock,
  input wire       rst,
  input wire       regWrite,
  input wire       regRead,
  input wire [3:0] regAddr,
  input wire [7:0] regWriteData,
  input wire [7:0] regReadData,
  input wire       regReadValid,
  input wire       gasOutResistorSw_q,
  input wire       gasAmplifierOn_q,
  input wire [2:0] batteryLoadCurrent_q,
  input wire       batteryLoadCodeReserved_q,
  input wire [7:0] boostSettings_q
);
  // outputs trail the register by one edge, so write checks look two edges on
  default clocking @(posedge clock); endclocking
  default disable iff (rst);
  a_read_pulse: assert property (regReadValid == $past(regRead)) else $error("valid late");
  a_read_bit3: assert property (regRead && regAddr == 4'hc |=> !regReadData[3])
    else $error("reserved bit set");
  a_read_unmap: assert property (regRead && regAddr == 4'hf |=> regReadData == 8'h00)
    else $error("unmapped read not zero");
  a_out_sw: assert property (regWrite && regAddr == 4'hc |-> ##2
    gasOutResistorSw_q == $past(regWriteData[7], 2)) else $error("output switch wrong");
  a_load_code: assert property (regWrite && regAddr == 4'hc |-> ##2
    batteryLoadCurrent_q == $past(regWriteData[2:0], 2)) else $error("load code wrong");
  a_code_flag: assert property (batteryLoadCodeReserved_q == (batteryLoadCurrent_q > 3'h5))
    else $error("reserved code flag wrong");
  a_amp_on: assert property (regWrite && regAddr == 4'hd |-> ##2
    gasAmplifierOn_q == $past(regWriteData[0], 2)) else $error("amplifier enable wrong");
  a_reset_bytes: assert property (disable iff (1'b0) rst [*2] |=>
    boostSettings_q == 8'hf2 && !gasAmplifierOn_q) else $error("reset value wrong");
endmodule // gas_amp_checks

bind gas_amp_battest_ctrl_regs gas_amp_checks u_checks (.clock, .rst, .regWrite, .regRead,
  .regAddr, .regWriteData, .regReadData, .regReadValid, .gasOutResistorSw_q,
  .gasAmplifierOn_q, .batteryLoadCurrent_q, .batteryLoadCodeReserved_q, .boostSettings_q);

/* tb/host_port_model.sv */
// host side model driving the parallel register strobes
`timescale 1ns/10ps
module host_port_model (
  input  wire        clock,
  input  wire        regReadValid,
  input  wire  [7:0] regReadData,
  output logic       regWrite = 1'b0,
  output logic       regRead = 1'b0,
  output logic [3:0] regAddr = 4'h0,
  output logic [7:0] regWriteData = 8'h00
);
  // released lines show the inverse of the last value so stale data never looks live
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(negedge clock);
    {regWrite, regAddr, regWriteData} = {1'b1, a, d};
    @(negedge clock);
    {regWrite, regAddr, regWriteData} = {1'b0, ~a, ~d};
  endtask
  // data is taken one cycle after the strobe while the valid pulse stands
  task automatic rd(input logic [3:0] a, output logic [7:0] d, output logic ok);
    @(negedge clock);
    {regRead, regAddr} = {1'b1, a};
    @(negedge clock);
    {regRead, regAddr} = {1'b0, ~a};
    ok = regReadValid === 1'b1;
    d = regReadData;
  endtask
endmodule // host_port_model

/* tb/gas_amp_battest_ctrl_regs_bench.sv */
// self-checking bench for the gas amplifier register bank
`timescale 1ns/10ps
`define CHK(n, e, s) checks_done++; if ((s) !== (e)) begin failures++; \
  $display("[FAIL] %s exp %h got %h", n, e, s); end
module gas_amp_battest_ctrl_regs_bench;
  logic       clock = 1'b0, rst = 1'b1, ok;
  logic [7:0] got, want;
  wire        regWrite, regRead, regReadValid;
  wire        outSw, gainSw, inSw, refSw, codeRes, bufOn, drvDir, drvOn, ampOn;
  wire  [2:0] loadCode;
  wire  [1:0] refLvl, fbSel;
  wire  [7:0] boost;
  wire  [3:0] regAddr;
  wire  [7:0] regWriteData, regReadData;
  int         failures = 0, checks_done = 0;
  // row: address, byte written, byte read back
  logic [19:0] rows [9] = '{20'hca5a5, 20'hc5a52, 20'hc0e06, 20'hcfff7, 20'hd2929,
    20'hd5252, 20'hdfbfb, 20'he3c3c, 20'hf7700};
  always #5 clock = ~clock;
  host_port_model u_host (.clock, .regReadValid, .regReadData, .regWrite, .regRead,
    .regAddr, .regWriteData);
  gas_amp_battest_ctrl_regs u_dut (.clock, .rst, .regWrite, .regRead, .regAddr, .regWriteData,
    .regReadData, .regReadValid, .gasOutResistorSw_q(outSw), .gasGainResistorSw_q(gainSw),
    .gasInResistorSw_q(inSw), .gasReferenceSw_q(refSw), .batteryLoadCurrent_q(loadCode),
    .batteryLoadCodeReserved_q(codeRes), .ref300mvBufferOn_q(bufOn),
    .gasReferenceLevel_q(refLvl), .gasFeedbackSelect_q(fbSel), .gasTestDriveDir_q(drvDir),
    .gasTestDriveOn_q(drvOn), .gasAmplifierOn_q(ampOn), .boostSettings_q(boost));
  task automatic conclude();
    $display("checks %0d mismatches %0d", checks_done, failures);
    if (failures == 0 && checks_done > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  // a missing valid pulse ends the run at once
  task automatic check_read(input logic [3:0] a, input logic [7:0] e);
    u_host.rd(a, got, ok);
    if (!ok) begin
      failures++;
      $display("[FAIL] read valid exp 1 got %b", ok);
      conclude();
    end else begin
      `CHK("read data", e, got)
    end
  endtask
  initial begin
    repeat (6) @(negedge clock);
    rst = 1'b0;
    foreach (rows[i]) begin
      u_host.wr(rows[i][19:16], rows[i][15:8]);
      check_read(rows[i][19:16], rows[i][7:0]);
      want = rows[i][7:0];
      case (rows[i][19:16])
        4'hc: begin
          `CHK("switches", want[7:4], {outSw, gainSw, inSw, refSw})
          `CHK("load code", want[2:0], loadCode)
          `CHK("code flag", want[2:0] > 3'h5, codeRes)
        end
        4'hd: begin
          `CHK("amp levels", want[7:3], {bufOn, refLvl, fbSel})
          `CHK("amp drive", want[2:0], {drvDir, drvOn, ampOn})
        end
        4'he: begin
          `CHK("boost copy", want, boost)
        end
        default: begin
          `CHK("unmapped write", 8'h3c, boost)
        end
      endcase
      $display("row %0d done", i);
    end
    // a second reset in mid-run brings back the reset bytes
    rst = 1'b1;
    repeat (2) @(negedge clock);
    rst = 1'b0;
    check_read(4'hc, 8'h00);
    check_read(4'hd, 8'h00);
    check_read(4'he, 8'hf2);
    `CHK("reset switches", 8'h00, {outSw, gainSw, inSw, refSw, codeRes, loadCode})
    `CHK("reset amp", 8'h00, {bufOn, refLvl, fbSel, drvDir, drvOn, ampOn})
    `CHK("reset boost", 8'hf2, boost)
    $display("reset test done");
    conclude();
  end
endmodule // gas_amp_battest_ctrl_regs_bench
